// *** rtl/erbf_top.sv ***
/*
  Event readout buffer formatter: captures converted samples, packs them
  into header, data and end-of-event words in a circular event buffer,
  and serves them through a read-only window; also decodes configuration
  and ROM regions, with broadcast writes limited to 16 bits.
  Assumes samples and bus requests come from logic on clock_in; the slot
  pins come from the backplane and are synchronised here.
*/
`timescale 1ns/100ps
module erbf_top #(
  parameter int NCH = erbf_pkg::NCH_DEFAULT
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [4:0] slot_pins_in,
  input wire logic conv_start_in,
  input wire logic conv_valid_in,
  input wire logic [4:0] conv_channel_in,
  input wire logic [11:0] conv_value_in,
  input wire logic conv_overflow_in,
  input wire logic conv_done_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic wide_in,
  input wire logic broadcast_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic ack_out,
  output logic err_out,
  output logic rom_sel_out,
  output logic busy_out,
  output logic [23:0] event_count_out
);
  import erbf_pkg::*;
  localparam int HALF = NCH / 2;
  localparam int CW = $clog2(NCH);
  localparam logic [BUF_AW:0] NEED = (BUF_AW + 1)'(NCH + 2);
  //////////////////////////////////////////////////////////////////////////
  logic [4:0] slot;
  erbf_sync #(.W(5)) u_slot_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .pin_in(slot_pins_in),
    .level_out(slot)
  );
  erbf_state_t st;
  erbf_state_t next_st;
  logic [31:0] mem [BUF_DEPTH];
  logic [BUF_AW:0] wptr;
  logic [BUF_AW:0] rptr;
  logic [CW-1:0] idx;
  logic [5:0] cnt;
  logic [NCH-1:0] seen;
  logic [11:0] samp_val [NCH];
  logic [NCH-1:0] samp_ovf;
  logic [8:0] thr [NCH];
  logic [15:0] bit_set_two;
  logic [7:0] crate;
  logic [23:0] evcnt;
  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic win_hit;
  logic rom_hit;
  logic thr_hit;
  logic cfg_hit;
  logic buf_empty;
  logic rd_ok;
  logic wr_ok;
  logic win_rd;
  logic win_pop;
  logic wr_cfg;
  logic [CW-1:0] thr_idx;
  function automatic logic is_cfg(input logic [15:0] a);
    case (a)
      OFS_BIT_SET_ONE, OFS_BIT_CLEAR_ONE, OFS_IRQ_PRIORITY, OFS_IRQ_VECTOR_ID,
      OFS_CONTROL_ONE, OFS_BASE_ADDR_HIGH, OFS_BASE_ADDR_LOW, OFS_ONE_SHOT_RESET,
      OFS_EVENT_THRESHOLD, OFS_EVENT_BUMP, OFS_OFFSET_BUMP, OFS_TEST_LOAD,
      OFS_CLEAR_WINDOW, OFS_BIT_SET_TWO, OFS_BIT_CLEAR_TWO, OFS_MEMTEST_WRITE_ADDR,
      OFS_MEMTEST_WORD_HI, OFS_MEMTEST_WORD_LO, OFS_CRATE_NUMBER,
      OFS_EVENT_COUNT_CLEAR, OFS_PEDESTAL_CURRENT, OFS_MEMTEST_READ_ADDR,
      OFS_SOFT_COMMAND, OFS_SLIDE_VALUE: is_cfg = 1'b1;
      default: is_cfg = 1'b0;
    endcase
  endfunction : is_cfg
  assign win_hit = (addr_in <= WIN_LAST) && (addr_in[1:0] == 2'b00);
  assign rom_hit = (addr_in >= ROM_FIRST) && (addr_in <= ROM_LAST);
  assign thr_hit = (addr_in >= THR_FIRST) && (addr_in <= THR_LAST);
  assign cfg_hit = is_cfg(addr_in);
  assign thr_idx = CW'((addr_in - THR_FIRST) >> 1);
  assign buf_empty = (wptr == rptr);
  assign rd_ok = !write_in && !broadcast_in && (win_hit || rom_hit);
  assign wr_ok = write_in && !wide_in && (cfg_hit || thr_hit);
  assign win_rd = req_in && rd_ok && win_hit;
  assign win_pop = win_rd && !buf_empty;
  assign wr_cfg = req_in && wr_ok;
  //////////////////////////////////////////////////////////////////////////
  // Bus answer, one cycle after the request
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      rom_sel_out <= 1'b0;
      rdata_out <= 32'h00000000;
      rptr <= '0;
    end else begin
      ack_out <= req_in && (rd_ok || wr_ok);
      err_out <= req_in && !(rd_ok || wr_ok);
      rom_sel_out <= req_in && rd_ok && rom_hit;
      if (win_pop) begin
        rdata_out <= mem[rptr[BUF_AW-1:0]];
        rptr <= rptr + 1'b1;
      end else if (win_rd) begin
        rdata_out <= {5'h00, TYPE_NOT_VALID, 24'h000000};
      end else if (req_in) begin
        rdata_out <= 32'h00000000;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic evcnt_bump;
  logic evcnt_clear;
  logic store_below;
  assign evcnt_clear = wr_cfg && (addr_in == OFS_EVENT_COUNT_CLEAR);
  assign store_below = bit_set_two[STORE_BELOW_A] || bit_set_two[STORE_BELOW_B];
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      bit_set_two <= BIT_SET_TWO_RST;
      crate <= CRATE_RST;
    end else if (wr_cfg) begin
      if (addr_in == OFS_BIT_SET_TWO) begin
        bit_set_two <= bit_set_two | wdata_in;
      end
      if (addr_in == OFS_BIT_CLEAR_TWO) begin
        bit_set_two <= bit_set_two & ~wdata_in;
      end
      if (addr_in == OFS_CRATE_NUMBER) begin
        crate <= wdata_in[7:0];
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NCH; i++) begin
        thr[i] <= THR_RST;
      end
    end else if (wr_cfg && thr_hit) begin
      thr[thr_idx] <= wdata_in[8:0];
    end
  end
  // A count in the same cycle as a clear restarts it at one so no event is lost
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      evcnt <= EVCNT_RST;
    end else if (evcnt_bump) begin
      evcnt <= evcnt_clear ? 24'h000001 : evcnt + 1'b1;
    end else if (evcnt_clear) begin
      evcnt <= EVCNT_RST;
    end
  end
  assign event_count_out = evcnt;
  //////////////////////////////////////////////////////////////////////////
  // Sample capture
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      seen <= '0;
    end else if (st == S_IDLE && conv_start_in) begin
      seen <= '0;
    end else if (st == S_CAPT && conv_valid_in) begin
      seen[conv_channel_in[CW-1:0]] <= 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (st == S_CAPT && conv_valid_in) begin
      samp_val[conv_channel_in[CW-1:0]] <= conv_value_in;
      samp_ovf[conv_channel_in[CW-1:0]] <= conv_overflow_in;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Scan order and suppression
  logic [CW-1:0] scan_ch;
  logic below;
  logic keep;
  logic [4:0] ch_field;
  logic [BUF_AW:0] used;
  logic room;
  logic last_idx;
  assign scan_ch = idx[0] ? CW'(HALF + int'(idx >> 1)) : CW'(idx >> 1);
  assign below = samp_val[scan_ch][11:4] < thr[scan_ch][7:0];
  assign keep = seen[scan_ch] && !thr[scan_ch][KILL_BIT] && (!below || store_below);
  assign ch_field = (NCH == 32) ? 5'(scan_ch) : {4'(scan_ch), 1'b0};
  assign used = wptr - rptr;
  assign room = (BUF_DEPTH - int'(used)) >= int'(NEED);
  assign last_idx = (idx == CW'(NCH - 1));
  assign busy_out = (st != S_IDLE) && (st != S_CAPT);
  assign evcnt_bump = (st == S_CAPT) && conv_done_in;
  always_comb begin
    next_st = st;
    case (st)
      S_IDLE: begin
        if (conv_start_in) begin
          next_st = S_CAPT;
        end
      end
      S_CAPT: begin
        if (conv_done_in) begin
          next_st = room ? S_SCAN : S_IDLE;
        end
      end
      S_SCAN: begin
        if (last_idx) begin
          next_st = S_CLOSE;
        end
      end
      S_CLOSE: next_st = (cnt == 6'h00) ? S_IDLE : S_HEAD;
      S_HEAD: next_st = S_TAIL;
      S_TAIL: next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
  end
  logic [23:0] eob_count;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st <= S_IDLE;
      idx <= '0;
      cnt <= 6'h00;
      wptr <= '0;
      eob_count <= EVCNT_RST;
    end else begin
      st <= next_st;
      if (evcnt_bump) begin
        eob_count <= evcnt;
        idx <= '0;
        cnt <= 6'h00;
      end
      if (st == S_SCAN) begin
        idx <= idx + 1'b1;
        if (keep) begin
          cnt <= cnt + 1'b1;
        end
      end
      if (st == S_TAIL) begin
        wptr <= wptr + (BUF_AW + 1)'(cnt) + 2'd2;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Word assembly
  logic mem_we;
  logic [BUF_AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] head_word;
  logic [31:0] data_word;
  logic [31:0] eob_word;
  assign head_word = {slot, TYPE_HEADER, crate, 2'b00, cnt, 8'h00};
  assign data_word = {slot, TYPE_DATUM, 3'b000, ch_field, 2'b00, below,
                      samp_ovf[scan_ch], samp_val[scan_ch]};
  assign eob_word = {slot, TYPE_EOB, eob_count};
  assign mem_we = (st == S_SCAN && keep) || (st == S_HEAD) || (st == S_TAIL);
  assign mem_waddr = (st == S_HEAD) ? wptr[BUF_AW-1:0]
                   : BUF_AW'(wptr + (BUF_AW + 1)'(cnt) + 1'b1);
  assign mem_wdata = (st == S_HEAD) ? head_word : (st == S_TAIL) ? eob_word : data_word;
  always_ff @(posedge clock_in) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking erbf_cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_empty_nv;
    (win_rd && buf_empty) |=> (ack_out && rdata_out[26:24] == TYPE_NOT_VALID
                               && rdata_out[31:27] == 5'h00);
  endproperty
  a_empty_nv: assert property (p_empty_nv) else $error("empty read not NV");
  property p_pop;
    win_pop |=> (rptr == $past(rptr) + 1'b1) && ack_out;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not advance");
  property p_head;
    (st == S_HEAD) |-> (mem_wdata[26:24] == TYPE_HEADER && mem_wdata[15:14] == 2'b00
                        && mem_wdata[23:16] == crate && mem_wdata[13:8] == cnt
                        && cnt != 6'h00);
  endproperty
  a_head: assert property (p_head) else $error("bad header");
  property p_data;
    (st == S_SCAN && keep) |-> (mem_wdata[26:24] == TYPE_DATUM
                                && mem_wdata[11:0] == samp_val[scan_ch]
                                && mem_wdata[13] == below);
  endproperty
  a_data: assert property (p_data) else $error("bad datum");
  property p_eob;
    (st == S_HEAD) |=> (st == S_TAIL && mem_wdata[26:24] == TYPE_EOB
                        && mem_wdata[23:0] == eob_count) ##1 (wptr != $past(wptr));
  endproperty
  a_eob: assert property (p_eob) else $error("bad end word");
  property p_slot;
    mem_we |-> mem_wdata[31:27] == slot;
  endproperty
  a_slot: assert property (p_slot) else $error("slot missing");
  property p_below;
    (st == S_SCAN && below && !store_below) |-> !mem_we;
  endproperty
  a_below: assert property (p_below) else $error("below stored");
  property p_bcast;
    (req_in && broadcast_in && (wide_in || !write_in)) |=> (err_out && !ack_out);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not refused");
  property p_rom;
    (req_in && !write_in && !broadcast_in && addr_in[15]) |=> (ack_out && rom_sel_out);
  endproperty
  a_rom: assert property (p_rom) else $error("rom not decoded");
  property p_order;
    (st == S_SCAN && idx == '0) |-> scan_ch == '0 ##1 (scan_ch == CW'(HALF));
  endproperty
  a_order: assert property (p_order) else $error("scan order wrong");
  c_event: cover property (@(posedge clock_in) st == S_TAIL);
  c_empty: cover property (@(posedge clock_in) win_rd && buf_empty);
  c_pop: cover property (@(posedge clock_in) win_pop);
  c_bcast: cover property (@(posedge clock_in) wr_cfg && broadcast_in);
endmodule : erbf_top

// *** rtl/erbf_pkg.sv ***
/*
  Shared constants of the event readout buffer formatter: offsets,
  word layouts, type codes and sizes.
  Assumes a 16-bit offset bus in front of the block.
*/
package erbf_pkg;
  // Address regions
  localparam logic [15:0] WIN_LAST = 16'h07FC;
  localparam logic [15:0] ROM_FIRST = 16'h8000;
  localparam logic [15:0] ROM_LAST = 16'hFFFF;
  localparam logic [15:0] THR_FIRST = 16'h1080;
  localparam logic [15:0] THR_LAST = 16'h10BF;
  // Configuration offsets
  localparam logic [15:0] OFS_BIT_SET_ONE = 16'h1006;
  localparam logic [15:0] OFS_BIT_CLEAR_ONE = 16'h1008;
  localparam logic [15:0] OFS_IRQ_PRIORITY = 16'h100A;
  localparam logic [15:0] OFS_IRQ_VECTOR_ID = 16'h100C;
  localparam logic [15:0] OFS_CONTROL_ONE = 16'h1010;
  localparam logic [15:0] OFS_BASE_ADDR_HIGH = 16'h1012;
  localparam logic [15:0] OFS_BASE_ADDR_LOW = 16'h1014;
  localparam logic [15:0] OFS_ONE_SHOT_RESET = 16'h1016;
  localparam logic [15:0] OFS_EVENT_THRESHOLD = 16'h1020;
  localparam logic [15:0] OFS_EVENT_BUMP = 16'h1028;
  localparam logic [15:0] OFS_OFFSET_BUMP = 16'h102A;
  localparam logic [15:0] OFS_TEST_LOAD = 16'h102C;
  localparam logic [15:0] OFS_CLEAR_WINDOW = 16'h102E;
  localparam logic [15:0] OFS_BIT_SET_TWO = 16'h1032;
  localparam logic [15:0] OFS_BIT_CLEAR_TWO = 16'h1034;
  localparam logic [15:0] OFS_MEMTEST_WRITE_ADDR = 16'h1036;
  localparam logic [15:0] OFS_MEMTEST_WORD_HI = 16'h1038;
  localparam logic [15:0] OFS_MEMTEST_WORD_LO = 16'h103A;
  localparam logic [15:0] OFS_CRATE_NUMBER = 16'h103C;
  localparam logic [15:0] OFS_EVENT_COUNT_CLEAR = 16'h1040;
  localparam logic [15:0] OFS_PEDESTAL_CURRENT = 16'h1060;
  localparam logic [15:0] OFS_MEMTEST_READ_ADDR = 16'h1064;
  localparam logic [15:0] OFS_SOFT_COMMAND = 16'h1068;
  localparam logic [15:0] OFS_SLIDE_VALUE = 16'h106A;
  // Word type codes, bits 26..24
  localparam logic [2:0] TYPE_HEADER = 3'h2;
  localparam logic [2:0] TYPE_DATUM = 3'h0;
  localparam logic [2:0] TYPE_EOB = 3'h4;
  localparam logic [2:0] TYPE_NOT_VALID = 3'h6;
  // Field positions
  localparam int TYPE_LSB = 24;
  localparam int SLOT_LSB = 27;
  localparam int BELOW_BIT = 13;
  localparam int OVER_BIT = 12;
  localparam int STORE_BELOW_A = 3;
  localparam int STORE_BELOW_B = 4;
  localparam int KILL_BIT = 8;
  // Reset values
  localparam logic [15:0] BIT_SET_TWO_RST = 16'h0000;
  localparam logic [7:0] CRATE_RST = 8'h00;
  localparam logic [8:0] THR_RST = 9'h000;
  localparam logic [23:0] EVCNT_RST = 24'h000000;
  // Buffer sizes
  localparam int BUF_DEPTH = 512;
  localparam int BUF_AW = 9;
  localparam int NCH_DEFAULT = 32;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CAPT = 3'b001,
    S_SCAN = 3'b010,
    S_CLOSE = 3'b011,
    S_HEAD = 3'b100,
    S_TAIL = 3'b101
  } erbf_state_t;
endpackage : erbf_pkg

// *** rtl/erbf_sync.sv ***
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes the inputs are quasi-static or may be sampled at any time.
*/
`timescale 1ns/100ps
module erbf_sync #(
  parameter int W = 5
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] stage_one;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      stage_one <= '0;
      level_out <= '0;
    end else begin
      stage_one <= pin_in;
      level_out <= stage_one;
    end
  end
endmodule : erbf_sync

// *** testbench/erbf_bus_master.sv ***
/*
  Bus master model: one-cycle requests, answer collected one edge later.
  Assumes the block answers every request with ack or err on the next edge.
*/
`timescale 1ns/100ps
module erbf_bus_master (
  input wire logic clock_in,
  output logic req_out,
  output logic write_out,
  output logic wide_out,
  output logic broadcast_out,
  output logic [15:0] addr_out,
  output logic [15:0] wdata_out,
  input wire logic [31:0] rdata_in,
  input wire logic ack_in,
  input wire logic err_in,
  input wire logic rom_sel_in
);
  initial begin
    req_out = 1'h0;
    write_out = 1'h0;
    wide_out = 1'h0;
    broadcast_out = 1'h0;
    addr_out = 16'hFFFF;
    wdata_out = 16'hFFFF;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic access(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] d,
                        output logic [31:0] rd, output logic [2:0] resp);
    @(posedge clock_in);
    req_out <= 1'h1;
    write_out <= kind[2];
    wide_out <= kind[1];
    broadcast_out <= kind[0];
    addr_out <= a;
    wdata_out <= d;
    @(posedge clock_in);
    req_out <= 1'h0;
    // Released address and data lines invert, so stale values never look valid
    addr_out <= ~a;
    wdata_out <= ~d;
    @(negedge clock_in);
    rd = rdata_in;
    resp = {ack_in, err_in, rom_sel_in};
  endtask : access
endmodule : erbf_bus_master

// *** testbench/erbf_top_tb.sv ***
/*
  Self-checking bench: table of bus accesses, then events, then reset.
  Assumes the bus master model and the block share clock_in.
*/
`timescale 1ns/100ps
module erbf_top_tb;
  import erbf_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [15:0] a;
    logic [15:0] d;
    logic [2:0] resp;
  } erbf_row_t;
  localparam logic [4:0] SLOT = 5'h15;
  logic clock_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic conv_start_in = 1'h0;
  logic conv_valid_in = 1'h0;
  logic [4:0] conv_channel_in = 5'h00;
  logic [11:0] conv_value_in = 12'h000;
  logic conv_overflow_in = 1'h0;
  logic conv_done_in = 1'h0;
  logic req, wr, wd, bc;
  logic [15:0] addr, wdata;
  logic [31:0] rdata_out;
  logic ack_out, err_out, rom_sel_out, busy_out;
  logic [23:0] event_count_out;
  logic [31:0] rd;
  logic [2:0] resp;
  logic [31:0] exp_w [11];
  erbf_row_t rows [14];
  int num_errors = 0;
  int cmp_count = 0;
  always #50 clock_in = ~clock_in;
  erbf_top #(.NCH(32)) erbf_top_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .slot_pins_in(SLOT), .conv_start_in(conv_start_in), .conv_valid_in(conv_valid_in),
    .conv_channel_in(conv_channel_in), .conv_value_in(conv_value_in),
    .conv_overflow_in(conv_overflow_in), .conv_done_in(conv_done_in), .req_in(req),
    .write_in(wr), .wide_in(wd), .broadcast_in(bc), .addr_in(addr), .wdata_in(wdata),
    .rdata_out(rdata_out), .ack_out(ack_out), .err_out(err_out), .rom_sel_out(rom_sel_out),
    .busy_out(busy_out), .event_count_out(event_count_out));
  erbf_bus_master erbf_bus_master_inst (.clock_in(clock_in), .req_out(req), .write_out(wr),
    .wide_out(wd), .broadcast_out(bc), .addr_out(addr), .wdata_out(wdata),
    .rdata_in(rdata_out), .ack_in(ack_out), .err_in(err_out), .rom_sel_in(rom_sel_out));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    erbf_bus_master_inst.access(3'h4, a, d, rd, resp);
    check("write response", {29'h0, resp}, 32'h00000004);
  endtask : wr16
  // First listed sample goes in first; n samples in all
  task automatic capture(input logic [2:0][4:0] c, input logic [2:0][11:0] v,
                         input logic [2:0] o, input int n);
    @(posedge clock_in);
    conv_start_in <= 1'h1;
    @(posedge clock_in);
    conv_start_in <= 1'h0;
    for (int i = 0; i < n; i++) begin
      conv_valid_in <= 1'h1;
      conv_channel_in <= c[2-i];
      conv_value_in <= v[2-i];
      conv_overflow_in <= o[2-i];
      @(posedge clock_in);
      conv_valid_in <= 1'h0;
      @(posedge clock_in);
    end
    conv_done_in <= 1'h1;
    @(posedge clock_in);
    conv_done_in <= 1'h0;
    @(negedge clock_in);
    check("busy", {31'h0, busy_out}, 32'h00000001);
    for (int i = 0; i < 200 && (i < 2 || busy_out !== 1'h0); i++) begin
      @(negedge clock_in);
    end
    check("idle", {31'h0, busy_out}, 32'h00000000);
    tick(2);
  endtask : capture
  function automatic logic [31:0] hdr(input logic [5:0] cnt);
    return {SLOT, TYPE_HEADER, 8'h5A, 2'h0, cnt, 8'h00};
  endfunction : hdr
  function automatic logic [31:0] dat(input logic [4:0] ch, input logic [1:0] flags,
                                      input logic [11:0] v);
    return {SLOT, TYPE_DATUM, 3'h0, ch, 2'h0, flags, v};
  endfunction : dat
  function automatic logic [31:0] end_of_event_word(input logic [23:0] n);
    return {SLOT, TYPE_EOB, n};
  endfunction : end_of_event_word
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    num_errors++;
    $display("Watchdog expired");
    report_and_stop();
  end
  initial begin
    rows = '{'{3'h0, 16'h0000, 16'h0000, 3'h4}, '{3'h0, 16'h8000, 16'h0000, 3'h5},
      '{3'h0, 16'hFFFC, 16'h0000, 3'h5}, '{3'h0, 16'h0800, 16'h0000, 3'h2},
      '{3'h0, 16'h103C, 16'h0000, 3'h2}, '{3'h1, 16'h0000, 16'h0000, 3'h2},
      '{3'h6, 16'h103C, 16'h0000, 3'h2}, '{3'h4, 16'h0000, 16'h0000, 3'h2},
      '{3'h4, 16'h10C0, 16'h0000, 3'h2}, '{3'h5, 16'h106A, 16'h0000, 3'h4},
      '{3'h5, 16'h10BE, 16'h0000, 3'h4}, '{3'h4, 16'h103C, 16'h005A, 3'h4},
      '{3'h4, 16'h1082, 16'h0010, 3'h4}, '{3'h4, 16'h10A2, 16'h0100, 3'h4}};
    tick(3);
    reset_n_in <= 1'h1;
    foreach (rows[i]) begin
      erbf_bus_master_inst.access(rows[i].kind, rows[i].a, rows[i].d, rd, resp);
      check("response", {29'h0, resp}, {29'h0, rows[i].resp});
      if (rows[i].resp[2] && !rows[i].kind[2]) begin
        check("read data", rd, (rows[i].a == 16'h0000) ? 32'h06000000 : 32'h0);
      end
    end
    $display("Test access table done");
    capture({5'h10, 5'h00, 5'h01}, {12'hABC, 12'h123, 12'h050}, 3'h4, 3);
    check("event count", {8'h00, event_count_out}, 32'h00000001);
    wr16(16'h1032, 16'h0008);
    capture({5'h1F, 5'h11, 5'h01}, {12'hFFF, 12'h200, 12'h050}, 3'h4, 3);
    check("event count", {8'h00, event_count_out}, 32'h00000002);
    wr16(16'h1040, 16'h0000);
    check("event count", {8'h00, event_count_out}, 32'h00000000);
    wr16(16'h1034, 16'h0008);
    wr16(16'h1032, 16'h0010);
    capture({5'h01, 5'h00, 5'h00}, {12'h050, 12'h000, 12'h000}, 3'h0, 1);
    exp_w = '{hdr(6'h02), dat(5'h00, 2'h0, 12'h123), dat(5'h10, 2'h1, 12'hABC), end_of_event_word(24'h0),
      hdr(6'h02), dat(5'h01, 2'h2, 12'h050), dat(5'h1F, 2'h1, 12'hFFF), end_of_event_word(24'h1),
      hdr(6'h01), dat(5'h01, 2'h2, 12'h050), end_of_event_word(24'h0)};
    foreach (exp_w[i]) begin
      erbf_bus_master_inst.access(3'h0, (i == 10) ? 16'h07FC : 16'(i * 4), 16'h0, rd, resp);
      check("window word", rd, exp_w[i]);
      check("window ack", {29'h0, resp}, 32'h00000004);
    end
    $display("Test events done");
    capture({5'h00, 5'h00, 5'h00}, {12'h123, 12'h000, 12'h000}, 3'h0, 1);
    reset_n_in <= 1'h0;
    tick(3);
    @(negedge clock_in);
    check("count in reset", {8'h00, event_count_out}, 32'h00000000);
    check("ack in reset", {31'h0, ack_out}, 32'h00000000);
    @(posedge clock_in);
    reset_n_in <= 1'h1;
    erbf_bus_master_inst.access(3'h0, 16'h0000, 16'h0000, rd, resp);
    check("empty after reset", rd, 32'h06000000);
    $display("Test reset done");
    report_and_stop();
  end
endmodule : erbf_top_tb
